/* File: hdl/input_router.sv */
// Routes the binary field inputs to internal protection functions
//
// Behaviour
// R01: Each input owns its own independent switch group selecting its functions.
// R02: Target-clear switch set: input activation clears targets; clear leaves them.
// R03: Second clear switch: activation clears targets and unlatches output contacts.
// R04: Third clear switch: clears targets, memorized values, unlatches contacts.
// R05: Group select enabled: energized input picks group 2, else group 1.
// R06: Configurer keeps the group select switch equal in both setting groups.
// R07: Time-sync switch set: input signal synchronizes internal time.
// R08: External-trip switch set: active input asserts external trip.
// R09: Breaker-failure switch set: activation starts breaker failure protection.
// R10: Lockout trigger switch set: activation sets trip lockout.
// R11: Arc switch set: active input is an external arc light indication.
// R12: Lockout reset switch set: activation clears trip lockout.
// R13: Per-element block switches suppress trip of that element while input active.
// R14: Auto-reclose disable switch: function disabled while input active.
// R15: Reclosing disable switch: breaker reclosing prevented while input active.
// R16: Auto-reclose initiation switch: activation initiates an auto-reclose sequence.
// R17: Breaker-open switch: input taken as breaker open indication.
// R18: Several inputs on one function combine by logical OR.
// R19: After reset every switch of every input is zero.
module input_router
    import input_router_pkg::*;
#(
    parameter int NUM_INPUTS = 5,
    parameter int ADDR_W     = 8
)(
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    // Register port
    input  wire logic [ADDR_W-1:0]    i_addr,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [31:0]          o_rdata,
    // Field inputs
    input  wire logic [NUM_INPUTS-1:0] i_binary_input,
    // Clear commands
    output logic                      o_clear_targets,
    output logic                      o_unlatch_outputs,
    output logic                      o_clear_memorized,
    // Settings and time
    output logic                      o_setting_group2,
    output logic                      o_time_sync,
    // Protection functions
    output logic                      o_external_trip,
    output logic                      o_breaker_failure_start,
    output logic                      o_trip_lockout,
    output logic                      o_arc_light,
    output logic [BLOCK_COUNT-1:0]    o_block_trip,
    // Auto-reclose and breaker
    output logic                      o_auto_reclose_disable,
    output logic                      o_reclose_disable,
    output logic                      o_auto_reclose_initiate,
    output logic                      o_breaker_open,
    output logic                      o_breaker_closed,
    // Interrupt
    output logic                      o_irq
);

    // Five switch groups at most, and the map needs five to eight address bits
    if (NUM_INPUTS < 1 || NUM_INPUTS > 5)
    begin : g_bad_inputs
        $error("NUM_INPUTS must be 1 to 5");
    end
    if (ADDR_W < 5 || ADDR_W > 8)
    begin : g_bad_addr
        $error("ADDR_W must be 5 to 8");
    end

    logic [SW_WIDTH-1:0]   route [NUM_INPUTS];
    logic [NUM_INPUTS-1:0] prev_input;
    logic [IRQ_WIDTH-1:0]  irq_status;
    logic [IRQ_WIDTH-1:0]  irq_mask;

    wire logic [NUM_INPUTS-1:0] rise = i_binary_input & ~prev_input;

    // Per-input contributions: level while active, pulse on activation
    logic [SW_WIDTH-1:0] level_row [NUM_INPUTS];
    logic [SW_WIDTH-1:0] rise_row  [NUM_INPUTS];
    logic [NUM_INPUTS-1:0] route_hit;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++)
        begin : g_input
            wire logic [ADDR_W-1:0] my_addr =
                ADDR_W'(ADDR_ROUTE_BASE) + ADDR_W'(4 * gi);
            assign route_hit[gi] = (i_addr == my_addr);
            // Each input is weighed only against its own switch group
            assign level_row[gi] = route[gi] & {SW_WIDTH{i_binary_input[gi]}};  // see R01
            assign rise_row[gi]  = route[gi] & {SW_WIDTH{rise[gi]}};  // see R01

            always_ff @(posedge i_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                    route[gi] <= ROUTE_RESET;  // see R19
                else if (i_wr && route_hit[gi])
                    route[gi] <= i_wdata[SW_WIDTH-1:0];
            end
        end
    endgenerate

    // Same function on several inputs: OR across inputs
    logic [SW_WIDTH-1:0] level_any;
    logic [SW_WIDTH-1:0] rise_any;
    always_comb
    begin
        level_any = '0;
        rise_any  = '0;
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            level_any = level_any | level_row[i];  // see R18
            rise_any  = rise_any | rise_row[i];  // see R18
        end
    end

    // Clear commands are one-cycle pulses on the activating edge
    wire logic next_clear_targets = rise_any[SW_CLEAR_TARGETS]  // see R02
        | rise_any[SW_CLEAR_UNLATCH]  // see R03
        | rise_any[SW_CLEAR_MEMORY];  // see R04
    wire logic next_unlatch = rise_any[SW_CLEAR_UNLATCH]  // see R03
        | rise_any[SW_CLEAR_MEMORY];  // see R04
    wire logic next_clear_memorized = rise_any[SW_CLEAR_MEMORY];  // see R04

    // Group 2 only while an enabled input is energized, else group 1
    wire logic next_group2 = level_any[SW_GROUP_SELECT];  // see R05

    // Set wins over a same-cycle reset, so a rising lockout request is never lost
    wire logic lock_set = rise_any[SW_LOCKOUT_SET];  // see R10
    wire logic lock_clr = rise_any[SW_LOCKOUT_RESET];  // see R12
    wire logic next_lockout = lock_set | (o_trip_lockout & ~lock_clr);

    wire logic [BLOCK_COUNT-1:0] next_block =
        level_any[SW_BLOCK_FIRST +: BLOCK_COUNT];  // see R13

    // Sync follows the raw signal so the time base sees its own edge
    wire logic next_time_sync            = level_any[SW_TIME_SYNC];  // see R07
    wire logic next_external_trip        = level_any[SW_EXT_TRIP];  // see R08
    wire logic next_breaker_fail         = level_any[SW_BRK_FAIL];  // see R09
    wire logic next_arc_light            = level_any[SW_ARC_LIGHT];  // see R11
    wire logic next_auto_reclose_disable = level_any[SW_AUTO_REC_OFF];  // see R14
    wire logic next_reclose_disable      = level_any[SW_RECLOSE_OFF];  // see R15
    wire logic next_breaker_open         = level_any[SW_BRK_OPEN];  // see R17
    wire logic next_breaker_closed       = level_any[SW_BRK_CLOSED];
    // One initiation per activation, so a held input starts only one sequence
    wire logic next_auto_reclose_init    = rise_any[SW_AUTO_REC_INIT];  // see R16

    // Register port decode
    wire logic hit_state  = (i_addr == ADDR_W'(ADDR_STATE));
    wire logic hit_status = (i_addr == ADDR_W'(ADDR_IRQ_STATUS));
    wire logic hit_mask   = (i_addr == ADDR_W'(ADDR_IRQ_MASK));

    logic [SW_WIDTH-1:0] route_rd;
    always_comb
    begin
        route_rd = '0;
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            if (route_hit[i])
                route_rd = route[i];
        end
    end

    wire logic [31:0] state_word = {
        24'h000000,
        o_setting_group2,
        o_trip_lockout,
        6'(i_binary_input)
    };

    wire logic [31:0] next_rdata =
        (|route_hit) ? {12'h000, route_rd} :
        hit_state    ? state_word :
        hit_status   ? {27'h0000000, irq_status} :
        hit_mask     ? {27'h0000000, irq_mask} :
        32'h00000000;

    // Interrupt events; a read clears, but a same-cycle event survives
    wire logic [IRQ_WIDTH-1:0] irq_event;
    assign irq_event[IRQ_CLEAR]   = next_clear_targets;
    assign irq_event[IRQ_LOCKOUT] = lock_set & ~o_trip_lockout;
    assign irq_event[IRQ_TRIP]    = next_external_trip & ~o_external_trip;
    assign irq_event[IRQ_RECLOSE] = next_auto_reclose_init;
    assign irq_event[IRQ_GROUP]   = next_group2 != o_setting_group2;
    wire logic irq_read_clear = i_rd && hit_status;
    wire logic [IRQ_WIDTH-1:0] next_irq_status =
        (irq_read_clear ? '0 : irq_status) | irq_event;
    wire logic next_irq = |(next_irq_status & irq_mask);

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            prev_input <= '0;
        else
            prev_input <= i_binary_input;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            irq_status <= '0;
        else
            irq_status <= next_irq_status;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            irq_mask <= IRQ_MASK_RESET;
        else if (i_wr && hit_mask)
            irq_mask <= i_wdata[IRQ_WIDTH-1:0];
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_rdata <= '0;
        else
            o_rdata <= i_rd ? next_rdata : 32'h00000000;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_irq <= 1'b0;
        else
            o_irq <= next_irq;
    end

    // One short register per output keeps every pin straight off a flip-flop
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_clear_targets <= 1'b0;
        else
            o_clear_targets <= next_clear_targets;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_unlatch_outputs <= 1'b0;
        else
            o_unlatch_outputs <= next_unlatch;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_clear_memorized <= 1'b0;
        else
            o_clear_memorized <= next_clear_memorized;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_setting_group2 <= 1'b0;
        else
            o_setting_group2 <= next_group2;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_time_sync <= 1'b0;
        else
            o_time_sync <= next_time_sync;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_external_trip <= 1'b0;
        else
            o_external_trip <= next_external_trip;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_breaker_failure_start <= 1'b0;
        else
            o_breaker_failure_start <= next_breaker_fail;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_trip_lockout <= 1'b0;
        else
            o_trip_lockout <= next_lockout;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_arc_light <= 1'b0;
        else
            o_arc_light <= next_arc_light;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_block_trip <= '0;
        else
            o_block_trip <= next_block;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_auto_reclose_disable <= 1'b0;
        else
            o_auto_reclose_disable <= next_auto_reclose_disable;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_reclose_disable <= 1'b0;
        else
            o_reclose_disable <= next_reclose_disable;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_auto_reclose_initiate <= 1'b0;
        else
            o_auto_reclose_initiate <= next_auto_reclose_init;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_breaker_open <= 1'b0;
        else
            o_breaker_open <= next_breaker_open;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_breaker_closed <= 1'b0;
        else
            o_breaker_closed <= next_breaker_closed;
    end

endmodule : input_router

/* File: hdl/input_router_pkg.sv */
// Constants shared by the digital input function router
package input_router_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_ROUTE_BASE = 8'h00;
    localparam logic [7:0] ADDR_STATE      = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h1C;

    // Switch positions inside each route register (switch n at bit n-1)
    localparam int SW_CLEAR_TARGETS = 0;
    localparam int SW_CLEAR_UNLATCH = 1;
    localparam int SW_CLEAR_MEMORY  = 2;
    localparam int SW_GROUP_SELECT  = 3;
    localparam int SW_TIME_SYNC     = 4;
    localparam int SW_EXT_TRIP      = 5;
    localparam int SW_BRK_FAIL      = 6;
    localparam int SW_LOCKOUT_SET   = 7;
    localparam int SW_ARC_LIGHT     = 8;
    localparam int SW_LOCKOUT_RESET = 9;
    localparam int SW_BLOCK_FIRST   = 10;
    localparam int SW_AUTO_REC_OFF  = 15;
    localparam int SW_RECLOSE_OFF   = 16;
    localparam int SW_BRK_OPEN      = 17;
    localparam int SW_BRK_CLOSED    = 18;
    localparam int SW_AUTO_REC_INIT = 19;
    localparam int SW_WIDTH         = 20;
    localparam int BLOCK_COUNT      = 5;

    // Route registers clear to no function at all
    localparam logic [SW_WIDTH-1:0] ROUTE_RESET = 20'h00000;

    // Interrupt status bit positions
    localparam int IRQ_CLEAR   = 0;
    localparam int IRQ_LOCKOUT = 1;
    localparam int IRQ_TRIP    = 2;
    localparam int IRQ_RECLOSE = 3;
    localparam int IRQ_GROUP   = 4;
    localparam int IRQ_WIDTH   = 5;
    localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 5'h00;
endpackage : input_router_pkg

/* File: verif/input_router_props.sv */
// Port-level assertions for the input router
module input_router_props
    import input_router_pkg::*;
#(
    parameter int NUM_INPUTS = 5
)(
    // Clock, reset and field inputs
    input wire logic                  i_clk,
    input wire logic                  i_rstn,
    input wire logic [NUM_INPUTS-1:0] i_binary_input,
    // Observed outputs
    input wire logic                  o_clear_targets,
    input wire logic                  o_unlatch_outputs,
    input wire logic                  o_clear_memorized,
    input wire logic                  o_setting_group2,
    input wire logic                  o_time_sync,
    input wire logic                  o_external_trip,
    input wire logic                  o_breaker_failure_start,
    input wire logic                  o_trip_lockout,
    input wire logic                  o_arc_light,
    input wire logic [BLOCK_COUNT-1:0] o_block_trip,
    input wire logic                  o_breaker_open,
    input wire logic                  o_auto_reclose_initiate,
    input wire logic                  o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Pulses need an input that rose; two inputs may rise on neighbouring cycles
    property p_clr; o_clear_targets |->
        ($past(i_binary_input) & ~$past(i_binary_input, 2)) != '0; endproperty
    property p_unl; o_unlatch_outputs |-> o_clear_targets; endproperty
    property p_mem; o_clear_memorized |-> o_unlatch_outputs && o_clear_targets; endproperty
    property p_ari; o_auto_reclose_initiate |->
        ($past(i_binary_input) & ~$past(i_binary_input, 2)) != '0; endproperty
    property p_idle; $past(i_binary_input) == '0 |-> !(o_external_trip
        || o_breaker_failure_start || o_arc_light || o_breaker_open || |o_block_trip); endproperty
    property p_grp; $past(i_binary_input) == '0 |-> !o_setting_group2; endproperty
    property p_syn; $past(i_binary_input) == '0 |-> !o_time_sync; endproperty
    property p_lset; $rose(o_trip_lockout) |-> $past(i_binary_input) != '0; endproperty
    property p_lclr; $fell(o_trip_lockout) |-> $past(i_binary_input) != '0; endproperty
    a_clr: assert property (p_clr)
        else $error("target clear without a rising input");
    a_unl: assert property (p_unl)
        else $error("unlatch without target clear");
    a_mem: assert property (p_mem)
        else $error("memory clear without unlatch and target clear");
    a_ari: assert property (p_ari)
        else $error("reclose initiation without a rising input");
    a_idle: assert property (p_idle)
        else $error("function driven with no input active");
    a_grp: assert property (p_grp)
        else $error("group 2 with no input active");
    a_syn: assert property (p_syn)
        else $error("time sync with no input active");
    a_lset: assert property (p_lset)
        else $error("lockout set with no input active");
    a_lclr: assert property (p_lclr)
        else $error("lockout cleared with no input active");
    c_mem: cover property (o_clear_memorized);
    c_lclr: cover property ($fell(o_trip_lockout));
    c_irq: cover property (o_irq);
endmodule : input_router_props

bind input_router input_router_props #(.NUM_INPUTS(NUM_INPUTS)) u_input_router_props (
    .i_clk, .i_rstn, .i_binary_input, .o_clear_targets, .o_unlatch_outputs,
    .o_clear_memorized, .o_setting_group2, .o_time_sync, .o_external_trip,
    .o_breaker_failure_start, .o_trip_lockout, .o_arc_light, .o_block_trip,
    .o_breaker_open, .o_auto_reclose_initiate, .o_irq);

/* File: verif/field_inputs_model.sv */
// Field side model: drives the binary inputs
module field_inputs_model
    import input_router_pkg::*;
(
    // Requested levels
    input  wire logic [4:0] i_level,
    // Input pins
    output logic      [4:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // Contacts are hard levels; no bounce is modelled, so every change counts
    assign o_pins = i_level;
endmodule : field_inputs_model

/* File: verif/testbench.sv */
// Self-checking bench for the input router
module testbench
    import input_router_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [19:0] LVL = 20'h7FD78;
    logic        i_clk, i_rstn, i_wr, i_rd, lock;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, d;
    logic [4:0]  level, i_binary_input, o_block_trip;
    logic        o_clear_targets, o_unlatch_outputs, o_clear_memorized, o_setting_group2;
    logic        o_time_sync, o_external_trip, o_breaker_failure_start, o_trip_lockout;
    logic        o_arc_light, o_auto_reclose_disable, o_reclose_disable, o_irq;
    logic        o_auto_reclose_initiate, o_breaker_open, o_breaker_closed;
    logic [19:0] rt [5];
    logic [19:0] want;
    int          fails, n_tests, cycles, seed, s, k, n;
    wire  logic [19:0] obs = {o_auto_reclose_initiate, o_breaker_closed, o_breaker_open,
        o_reclose_disable, o_auto_reclose_disable, o_block_trip, 1'b0, o_arc_light,
        o_trip_lockout, o_breaker_failure_start, o_external_trip, o_time_sync,
        o_setting_group2, o_clear_memorized, o_unlatch_outputs, o_clear_targets};
    input_router u_input_router (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_binary_input, .o_clear_targets, .o_unlatch_outputs, .o_clear_memorized,
        .o_setting_group2, .o_time_sync, .o_external_trip, .o_breaker_failure_start,
        .o_trip_lockout, .o_arc_light, .o_block_trip, .o_auto_reclose_disable,
        .o_reclose_disable, .o_auto_reclose_initiate, .o_breaker_open, .o_breaker_closed,
        .o_irq);
    field_inputs_model u_field_inputs_model (.i_level(level), .o_pins(i_binary_input));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask : chk
    task bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
        @(posedge i_clk) i_wr <= 1'b0;
    endtask : bus_wr
    task bus_rd(input logic [7:0] a);
        @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk) i_rd <= 1'b0;
        @(negedge i_clk) d = o_rdata;
    endtask : bus_rd
    task pulse_in(input logic [4:0] p);
        @(posedge i_clk) level <= p;
        @(posedge i_clk) level <= 5'h0;
        repeat (3) @(negedge i_clk);
    endtask : pulse_in
    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    function automatic logic [19:0] exp_pulse(input int sw, input logic lk);
        logic [19:0] e;
        e = (sw == SW_LOCKOUT_RESET) ? 20'h0 : 20'h1 << sw;
        if (sw == SW_CLEAR_UNLATCH || sw == SW_CLEAR_MEMORY)
            e = e | (e >> 1) | (e >> 2);
        e[SW_LOCKOUT_SET] = lk;
        return e;
    endfunction : exp_pulse
    function automatic logic [19:0] exp_or(input logic [4:0] p);
        logic [19:0] e;
        e = 20'h0;
        for (int i = 0; i < 5; i++)
            if (p[i])
                e = e | rt[i];
        return e;
    endfunction : exp_or
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    // Generous ceiling; the whole run needs about 630 cycles
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            $display("MISMATCH %0t timeout", $time);
            fails++;
            end_sim();
        end
    end
    initial
    begin
        {i_rstn, i_wr, i_rd, i_addr, i_wdata, level, lock} = '0;
        seed = 47;
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        for (k = 0; k < 5; k++)
        begin
            bus_rd(8'(4 * k));
            chk(d, 32'(ROUTE_RESET));
        end
        bus_rd(ADDR_IRQ_MASK);
        chk(d, 32'(IRQ_MASK_RESET));
        bus_wr(8'h40, 32'hFFFFFFFF);
        bus_rd(8'h40);
        chk(d, 32'h0);
        $display("reset and map test done");
        for (s = 0; s < SW_WIDTH; s++)
        begin
            k = $unsigned($random(seed)) % 5;
            lock = (s == SW_LOCKOUT_SET) ? 1'b1 : (s == SW_LOCKOUT_RESET) ? 1'b0 : lock;
            bus_wr(8'(4 * k), 32'h1 << s);
            @(posedge i_clk) level <= 5'h1 << k;
            @(posedge i_clk);
            @(negedge i_clk) chk(obs, exp_pulse(s, lock));
            @(negedge i_clk) chk(obs, exp_pulse(s, lock) & 20'h7FFF8);
            @(posedge i_clk) level <= 5'h0;
            bus_wr(8'(4 * k), 32'h0);
        end
        bus_rd(ADDR_IRQ_STATUS);
        chk(d, 32'({IRQ_WIDTH{1'b1}}));
        $display("switch walk test done");
        for (k = 0; k < 5; k++)
        begin
            rt[k] = 20'($random(seed)) & LVL;
            bus_wr(8'(4 * k), 32'(rt[k]));
        end
        for (n = 0; n < 200; n++)
        begin
            @(posedge i_clk) level <= 5'($random(seed));
            @(negedge i_clk);
            @(negedge i_clk) chk(obs & LVL, exp_or(level));
        end
        want = exp_or(level);
        bus_rd(ADDR_STATE);
        chk(d, {24'h000000, want[SW_GROUP_SELECT], 2'h0, level});
        @(posedge i_clk) level <= 5'h0;
        $display("random routing test done");
        bus_wr(ADDR_ROUTE_BASE, 32'h1);
        bus_wr(ADDR_IRQ_MASK, 32'h1);
        repeat (3) bus_rd(ADDR_IRQ_STATUS);
        pulse_in(5'h1);
        chk(o_irq, 1'b1);
        bus_rd(ADDR_IRQ_STATUS);
        chk(d, 32'h1);
        @(negedge i_clk) chk(o_irq, 1'b0);
        bus_wr(ADDR_IRQ_MASK, 32'h0);
        pulse_in(5'h1);
        chk(o_irq, 1'b0);
        bus_rd(ADDR_IRQ_STATUS);
        chk(d, 32'h1);
        $display("interrupt test done");
        end_sim();
    end
endmodule : testbench
